// *** verilog/fos_status_reporter.sv ***
// Overview of operation
// RULE1 - status byte is driven on the low byte of the data lines
// RULE2 - program, erase, protect, unprotect or resume commands switch reads to status
// RULE3 - status mode returns the status byte whatever address is presented
// RULE4 - status reads use asynchronous or single synchronous cycles only, never burst
// RULE5 - back in array mode, read behaviour follows the configuration register again
// RULE6 - while busy, shown status refreshes only at a new read cycle
// RULE7 - the four error flags are sticky until clear command or reset
// RULE8 - idle flag low while busy with other bits floating, high when inactive
// RULE9 - after suspend the idle flag stays low until the controller pauses
// RULE10 - host polls idle flag, then checks the error flags
// RULE11 - erase paused flag high while erase suspended, low after resume
// RULE12 - program paused flag high while program suspended, low after resume
// RULE13 - controller may finish instead of suspending; pause flags valid only when idle
// RULE14 - erase verify failure after maximum pulses sets erase fail only
// RULE15 - erase or unprotect with enable pin low sets erase and voltage faults
// RULE16 - erase on a locked block sets erase fail and locked fault
// RULE17 - wrong command sequence sets both program fail and erase fail
// RULE18 - program verify failure after maximum pulses sets program fail only
// RULE19 - program or protect with enable pin low sets program and voltage faults
// RULE20 - program on a locked block sets program fail and locked fault
// RULE21 - voltage fault records any operation tried with enable pin low; code sets it only for an accepted start without a sequence error
// RULE22 - a left set error flag makes new operations appear to fail
// RULE23 - bit zero is reserved and reads zero
// RULE24 - program suspended inside erase suspend shows both paused flags, no errors
// RULE25 - reset clears errors and paused flags, idle flag high
`timescale 1ns/1ps
module fos_status_reporter (
	input  wire logic                   core_clk,
	input  wire logic                   srst,
	input  wire logic                   cmdValid,
	input  wire fos_pkg::fos_cmd_t      cmd,
	input  wire logic                   cmdSeqError,
	input  wire logic                   targetLocked,
	input  wire logic                   programEraseEnablePin,
	input  wire fos_pkg::fos_rdmode_t   cfgReadMode,
	input  wire logic                   ceN,
	input  wire logic                   oeN,
	input  wire fos_pkg::fos_eng_rsp_t  engRsp,
	output fos_pkg::fos_eng_req_t       engReq,
	output logic [7:0]                  lowByteDataLines,
	output logic [7:0]                  lowByteOe,
	output logic                        statusMode,
	output fos_pkg::fos_rdmode_t        busReadMode
);

	////////////////////////////////////////////////////////////////////////////////
	// read cycle detection

	logic readActive;
	logic refresh;

	fos_read_cycle uRead (
		.core_clk   (core_clk),
		.srst       (srst),
		.ceN        (ceN),
		.oeN        (oeN),
		.readActive (readActive),
		.refresh    (refresh)
	);

	////////////////////////////////////////////////////////////////////////////////
	// state

	fos_pkg::fos_state_t q;
	fos_pkg::fos_state_t d;

	logic isStart;
	logic eraseKind;
	logic lockCheck;
	logic anySticky;
	logic canStart;
	logic busyNow;

	always_comb begin
		isStart   = cmdValid && (cmd == fos_pkg::CMD_PROGRAM || cmd == fos_pkg::CMD_ERASE ||
			cmd == fos_pkg::CMD_PROTECT || cmd == fos_pkg::CMD_UNPROTECT);
		eraseKind = (cmd == fos_pkg::CMD_ERASE) || (cmd == fos_pkg::CMD_UNPROTECT);
		lockCheck = (cmd == fos_pkg::CMD_PROGRAM) || (cmd == fos_pkg::CMD_ERASE);
		anySticky = q.flags.eraseFail || q.flags.programFail ||
			q.flags.enableVoltageFault || q.flags.lockedBlockFault;
		busyNow   = (q.ctl == fos_pkg::CTL_BUSY) || (q.ctl == fos_pkg::CTL_SUSPEND);
		// new work only when idle, or a program while an erase sits suspended
		canStart  = (q.ctl == fos_pkg::CTL_IDLE) ||
			((q.ctl == fos_pkg::CTL_PAUSED) && q.flags.erasePaused &&
			!q.flags.programPaused && (cmd == fos_pkg::CMD_PROGRAM));
	end

	always_comb begin
		d     = q;
		d.eng = '0;

		// clear first so that any set below in the same cycle wins
		if (cmdValid && cmd == fos_pkg::CMD_CLEAR) begin
			d.flags.eraseFail          = 1'b0; // [RULE7]
			d.flags.programFail        = 1'b0; // [RULE7]
			d.flags.enableVoltageFault = 1'b0; // [RULE7]
			d.flags.lockedBlockFault   = 1'b0; // [RULE7]
		end

		if (cmdValid && cmd == fos_pkg::CMD_RD_STATUS) begin
			d.statusMode = 1'b1;
		end
		if (cmdValid && cmd == fos_pkg::CMD_RD_ARRAY) begin
			d.statusMode = 1'b0; // [RULE5]
		end

		case (q.ctl)
			fos_pkg::CTL_IDLE, fos_pkg::CTL_PAUSED: begin
				if (isStart && canStart) begin
					d.statusMode = 1'b1; // [RULE2]
					if (cmdSeqError) begin
						d.flags.programFail = 1'b1; // [RULE17]
						d.flags.eraseFail   = 1'b1; // [RULE17]
					end else if (!programEraseEnablePin) begin
						d.flags.enableVoltageFault = 1'b1; // [RULE21]
						if (eraseKind) begin
							d.flags.eraseFail = 1'b1; // [RULE15]
						end else begin
							d.flags.programFail = 1'b1; // [RULE19]
						end
					end else if (targetLocked && lockCheck) begin
						d.flags.lockedBlockFault = 1'b1;
						if (eraseKind) begin
							d.flags.eraseFail = 1'b1; // [RULE16]
						end else begin
							d.flags.programFail = 1'b1; // [RULE20]
						end
					end else if (!anySticky) begin // [RULE22]
						d.ctl         = fos_pkg::CTL_BUSY;
						d.eng.start   = 1'b1;
						d.eng.isErase = eraseKind;
						d.curErase    = eraseKind;
					end
				end else if (cmdValid && cmd == fos_pkg::CMD_RESUME &&
					q.ctl == fos_pkg::CTL_PAUSED) begin
					d.statusMode = 1'b1; // [RULE2]
					d.ctl        = fos_pkg::CTL_BUSY;
					d.eng.resume = 1'b1;
					// innermost suspension resumes first
					if (q.flags.programPaused) begin
						d.flags.programPaused = 1'b0; // [RULE12]
						d.curErase            = 1'b0;
					end else begin
						d.flags.erasePaused = 1'b0; // [RULE11]
						d.curErase          = 1'b1;
					end
					d.eng.isErase = d.curErase;
				end
			end
			fos_pkg::CTL_BUSY, fos_pkg::CTL_SUSPEND: begin
				if (engRsp.done) begin
					// finishing beats a pending suspend
					d.ctl = q.flags.erasePaused ? fos_pkg::CTL_PAUSED : fos_pkg::CTL_IDLE; // [RULE13]
					if (engRsp.fail) begin
						if (q.curErase) begin
							d.flags.eraseFail = 1'b1; // [RULE14]
						end else begin
							d.flags.programFail = 1'b1; // [RULE18]
						end
					end
				end else if (q.ctl == fos_pkg::CTL_SUSPEND) begin
					if (engRsp.paused) begin
						d.ctl = fos_pkg::CTL_PAUSED; // [RULE9]
						if (q.curErase) begin
							d.flags.erasePaused = 1'b1; // [RULE11]
						end else begin
							d.flags.programPaused = 1'b1; // [RULE12] [RULE24]
						end
					end
				end else if (cmdValid && cmd == fos_pkg::CMD_SUSPEND) begin
					d.ctl         = fos_pkg::CTL_SUSPEND;
					d.eng.suspend = 1'b1;
					d.eng.isErase = q.curErase;
				end
			end
			default: begin
				d.ctl = fos_pkg::CTL_IDLE;
			end
		endcase

		d.flags.ctlIdle        = (d.ctl == fos_pkg::CTL_IDLE) ||
			(d.ctl == fos_pkg::CTL_PAUSED); // [RULE8]
		d.flags.reservedLowBit = 1'b0; // [RULE23]

		// live while inactive, frozen during work until a new read cycle
		if (refresh || !busyNow) begin
			d.shown = q.flags; // [RULE6]
		end

		// status drives no matter what address is on the bus
		if (readActive && d.statusMode) begin // [RULE3]
			d.oeMask = busyNow ? fos_pkg::OE_BUSY_MASK : fos_pkg::OE_ALL_MASK; // [RULE8]
		end else begin
			d.oeMask = fos_pkg::OE_NONE_MASK;
		end

		if (d.statusMode && cfgReadMode == fos_pkg::RD_BURST) begin
			d.rdMode = fos_pkg::RD_SINGLE_SYNC; // [RULE4]
		end else begin
			d.rdMode = cfgReadMode; // [RULE5]
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			q            <= '0;
			q.ctl        <= fos_pkg::CTL_IDLE;
			q.flags      <= fos_pkg::STATUS_RESET; // [RULE25]
			q.shown      <= fos_pkg::STATUS_RESET;
			q.rdMode     <= fos_pkg::RD_ASYNC;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign engReq           = q.eng;
	assign lowByteDataLines = q.shown; // [RULE1]
	assign lowByteOe        = q.oeMask;
	assign statusMode       = q.statusMode;
	assign busReadMode      = q.rdMode;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	sticky_error_hold_a: assert property ( // [RULE7]
		$fell(q.flags.eraseFail) || $fell(q.flags.programFail) ||
		$fell(q.flags.enableVoltageFault) || $fell(q.flags.lockedBlockFault)
		|-> $past(cmdValid && cmd == fos_pkg::CMD_CLEAR))
		else $error("error flag dropped without clear");

	voltage_fault_set_a: assert property ( // [RULE21]
		isStart && canStart && !cmdSeqError && !programEraseEnablePin
		|=> q.flags.enableVoltageFault && q.ctl != fos_pkg::CTL_BUSY)
		else $error("enable pin low did not raise voltage fault");

	locked_erase_a: assert property ( // [RULE16]
		isStart && canStart && cmd == fos_pkg::CMD_ERASE && !cmdSeqError &&
		programEraseEnablePin && targetLocked
		|=> q.flags.eraseFail && q.flags.lockedBlockFault)
		else $error("locked erase not flagged");

	bad_sequence_a: assert property ( // [RULE17]
		isStart && canStart && cmdSeqError
		|=> q.flags.programFail && q.flags.eraseFail)
		else $error("bad sequence not flagged");

	suspend_wait_a: assert property ( // [RULE9]
		q.ctl == fos_pkg::CTL_SUSPEND && !engRsp.paused && !engRsp.done
		|=> q.ctl == fos_pkg::CTL_SUSPEND && !q.flags.ctlIdle)
		else $error("left suspending without pause");

	resume_erase_a: assert property ( // [RULE11]
		cmdValid && cmd == fos_pkg::CMD_RESUME && q.ctl == fos_pkg::CTL_PAUSED &&
		q.flags.erasePaused && !q.flags.programPaused
		|=> !q.flags.erasePaused ##1 q.ctl != fos_pkg::CTL_IDLE || $past(engRsp.done))
		else $error("erase paused flag held after resume");

	busy_float_a: assert property ( // [RULE8]
		busyNow && readActive && q.statusMode && !cmdValid
		|=> lowByteOe == fos_pkg::OE_BUSY_MASK)
		else $error("status bits driven while busy");

	auto_status_a: assert property ( // [RULE2]
		cmdValid && cmd == fos_pkg::CMD_RESUME && q.ctl == fos_pkg::CTL_PAUSED
		|=> statusMode && engReq.resume)
		else $error("resume did not select status reads");

	no_burst_a: assert property ( // [RULE4]
		statusMode |-> busReadMode != fos_pkg::RD_BURST)
		else $error("burst mode while reading status");

	reserved_zero_a: assert property ( // [RULE23]
		lowByteDataLines[fos_pkg::RESERVED_LOW_BIT] == 1'b0)
		else $error("reserved status bit set");

	frozen_busy_a: assert property ( // [RULE6]
		busyNow && !refresh |=> $stable(lowByteDataLines))
		else $error("status changed during work without new read");

	locked_program_a: assert property ( // [RULE20]
		isStart && canStart && cmd == fos_pkg::CMD_PROGRAM && !cmdSeqError &&
		programEraseEnablePin && targetLocked
		|=> q.flags.programFail && q.flags.lockedBlockFault)
		else $error("locked program not flagged");

	pin_low_erase_a: assert property ( // [RULE15]
		isStart && canStart && !cmdSeqError && !programEraseEnablePin && eraseKind
		|=> q.flags.eraseFail && q.flags.enableVoltageFault)
		else $error("erase with enable pin low not flagged");

	pin_low_program_a: assert property ( // [RULE19]
		isStart && canStart && !cmdSeqError && !programEraseEnablePin && !eraseKind
		|=> q.flags.programFail && q.flags.enableVoltageFault)
		else $error("program with enable pin low not flagged");

	erase_verify_fail_a: assert property ( // [RULE14]
		busyNow && engRsp.done && engRsp.fail && q.curErase && !cmdValid
		|=> q.flags.eraseFail && $stable(q.flags.programFail))
		else $error("erase verify failure not flagged alone");

	program_verify_fail_a: assert property ( // [RULE18]
		busyNow && engRsp.done && engRsp.fail && !q.curErase && !cmdValid
		|=> q.flags.programFail && $stable(q.flags.eraseFail))
		else $error("program verify failure not flagged alone");

	sticky_no_start_a: assert property ( // [RULE22]
		isStart && canStart && anySticky |=> !engReq.start)
		else $error("operation started with an error flag set");

	start_status_a: assert property ( // [RULE2]
		isStart && canStart |=> statusMode)
		else $error("start did not select status reads");

	array_mode_a: assert property ( // [RULE5]
		cmdValid && cmd == fos_pkg::CMD_RD_ARRAY
		|=> !statusMode && busReadMode == $past(cfgReadMode))
		else $error("array mode did not restore read mode");

	busy_idle_low_a: assert property ( // [RULE8] [RULE9]
		busyNow && refresh |=> !lowByteDataLines[fos_pkg::CTL_IDLE_BIT])
		else $error("idle flag shown high while busy");

	paused_idle_high_a: assert property ( // [RULE9]
		q.ctl == fos_pkg::CTL_PAUSED |=> lowByteDataLines[fos_pkg::CTL_IDLE_BIT])
		else $error("idle flag low while paused");

	program_pause_busy_a: assert property ( // [RULE12]
		q.ctl == fos_pkg::CTL_BUSY |-> !q.flags.programPaused)
		else $error("program paused flag set while busy");

	resume_program_a: assert property ( // [RULE12]
		cmdValid && cmd == fos_pkg::CMD_RESUME && q.ctl == fos_pkg::CTL_PAUSED &&
		q.flags.programPaused
		|=> !q.flags.programPaused && !engReq.isErase && $stable(q.flags.erasePaused))
		else $error("program resume mishandled");

	shown_refresh_a: assert property ( // [RULE1] [RULE6]
		refresh |=> lowByteDataLines == $past(q.flags))
		else $error("new read did not load the status word");

	idle_drive_all_a: assert property ( // [RULE8]
		!busyNow && readActive && q.statusMode && !cmdValid
		|=> lowByteOe == fos_pkg::OE_ALL_MASK)
		else $error("status bits not driven while inactive");

	reset_state_a: assert property ( // [RULE25]
		$past(srst) |-> lowByteDataLines == fos_pkg::STATUS_RESET &&
		lowByteOe == fos_pkg::OE_NONE_MASK && !statusMode && engReq == '0)
		else $error("state after reset wrong");

endmodule

// *** verilog/fos_pkg.sv ***
package fos_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// status word layout, bit 7 down to bit 0
	typedef struct packed {
		logic ctlIdle;
		logic erasePaused;
		logic eraseFail;
		logic programFail;
		logic enableVoltageFault;
		logic programPaused;
		logic lockedBlockFault;
		logic reservedLowBit;
	} fos_status_t;

	localparam int unsigned CTL_IDLE_BIT     = 7;
	localparam int unsigned RESERVED_LOW_BIT = 0;

	localparam fos_status_t STATUS_RESET = fos_status_t'(8'h80);
	localparam logic [7:0]  OE_BUSY_MASK = 8'h80;
	localparam logic [7:0]  OE_ALL_MASK  = 8'hff;
	localparam logic [7:0]  OE_NONE_MASK = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// decoded commands from the command interface
	typedef enum logic [3:0] {
		CMD_NONE       = 4'h0,
		CMD_PROGRAM    = 4'h1,
		CMD_ERASE      = 4'h2,
		CMD_PROTECT    = 4'h3,
		CMD_UNPROTECT  = 4'h4,
		CMD_SUSPEND    = 4'h5,
		CMD_RESUME     = 4'h6,
		CMD_CLEAR      = 4'h7,
		CMD_RD_STATUS  = 4'h8,
		CMD_RD_ARRAY   = 4'h9
	} fos_cmd_t;

	// controller state, gray along idle, busy, suspending, paused
	typedef enum logic [1:0] {
		CTL_IDLE    = 2'b00,
		CTL_BUSY    = 2'b01,
		CTL_SUSPEND = 2'b11,
		CTL_PAUSED  = 2'b10
	} fos_ctl_t;

	typedef enum logic [1:0] {
		RD_ASYNC       = 2'h0,
		RD_SINGLE_SYNC = 2'h1,
		RD_BURST       = 2'h2
	} fos_rdmode_t;

	// requests to the array algorithm engine, one-cycle pulses
	typedef struct packed {
		logic start;
		logic resume;
		logic suspend;
		logic isErase;
	} fos_eng_req_t;

	typedef struct packed {
		logic done;
		logic fail;
		logic paused;
	} fos_eng_rsp_t;

	typedef struct packed {
		logic ceN;
		logic oeN;
		logic cycle;
		logic refresh;
	} fos_rd_state_t;

	typedef struct packed {
		fos_ctl_t     ctl;
		fos_status_t  flags;
		logic [7:0]   shown;
		logic [7:0]   oeMask;
		logic         statusMode;
		fos_rdmode_t  rdMode;
		fos_eng_req_t eng;
		logic         curErase;
	} fos_state_t;

	localparam fos_rd_state_t RD_STATE_RESET = fos_rd_state_t'(4'hc);

endpackage

// *** verilog/fos_read_cycle.sv ***
`timescale 1ns/1ps
module fos_read_cycle (
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic ceN,
	input  wire logic oeN,
	output logic      readActive,
	output logic      refresh
);

	fos_pkg::fos_rd_state_t q;
	fos_pkg::fos_rd_state_t d;

	// a refresh marks the start of a read: ce and oe both low after either one was high
	always_comb begin
		d         = q;
		d.ceN     = ceN;
		d.oeN     = oeN;
		d.cycle   = !ceN && !oeN;
		d.refresh = !ceN && !oeN && (q.ceN || q.oeN);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			q <= fos_pkg::RD_STATE_RESET;
		end else begin
			q <= d;
		end
	end

	assign readActive = q.cycle;
	assign refresh    = q.refresh;

endmodule

// *** dv/fos_host_model.sv ***
`timescale 1ns/1ps
module fos_host_model (
	input  wire logic       core_clk,
	output logic            ceN,
	output logic            oeN,
	input  wire logic [7:0] lowByteDataLines,
	input  wire logic [7:0] lowByteOe
);
	initial begin
		ceN = 1'b1;
		oeN = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// asynchronous read cycle only, a fresh one per call
	task automatic readOnce(output logic [7:0] data, output logic [7:0] oe);
		@(negedge core_clk);
		ceN = 1'b0;
		oeN = 1'b0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		// undriven lines float: modelled as the inverse of the last value
		data = (lowByteDataLines ^ ~lowByteOe) & 8'hfe;
		oe = lowByteOe;
		ceN = 1'b1;
		oeN = 1'b1;
		repeat (2) @(negedge core_clk);
	endtask

	// other bits only looked at once idle
	task automatic pollIdle(output logic [7:0] data, output logic [7:0] oe);
		int n;
		n = 0;
		readOnce(data, oe);
		while (data[fos_pkg::CTL_IDLE_BIT] !== 1'b1 && n < 60) begin
			readOnce(data, oe);
			n++;
		end
	endtask
endmodule

// *** dv/fos_status_reporter_test.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module fos_status_reporter_test;
	logic                  core_clk = 1'b0;
	logic                  srst = 1'b1;
	logic                  cmdValid = 1'b0;
	fos_pkg::fos_cmd_t     cmd = fos_pkg::CMD_NONE;
	logic                  cmdSeqError = 1'b0;
	logic                  targetLocked = 1'b0;
	logic                  programEraseEnablePin = 1'b1;
	fos_pkg::fos_rdmode_t  cfgReadMode = fos_pkg::RD_ASYNC;
	fos_pkg::fos_eng_rsp_t engRsp = '0;
	fos_pkg::fos_eng_req_t engReq;
	logic                  ceN;
	logic                  oeN;
	logic [7:0]            lowByteDataLines;
	logic [7:0]            lowByteOe;
	logic                  statusMode;
	fos_pkg::fos_rdmode_t  busReadMode;
	logic [7:0]            rd;
	logic [7:0]            oe;
	logic                  engFail = 1'b0;
	logic                  reqErase = 1'b0;
	logic                  finishOnSuspend = 1'b0;
	logic [31:0]           lfsr = 32'h72d35f53;
	int                    failures = 0;
	int                    checked = 0;
	int                    engCnt = 0;
	int                    pauseCnt = 0;
	int                    starts = 0;
	int                    lat = 3;
	int                    n;

	always #5 core_clk = ~core_clk;

	fos_status_reporter fos_status_reporter_i (.core_clk(core_clk), .srst(srst),
		.cmdValid(cmdValid), .cmd(cmd), .cmdSeqError(cmdSeqError),
		.targetLocked(targetLocked), .programEraseEnablePin(programEraseEnablePin),
		.cfgReadMode(cfgReadMode), .ceN(ceN), .oeN(oeN), .engRsp(engRsp), .engReq(engReq),
		.lowByteDataLines(lowByteDataLines), .lowByteOe(lowByteOe),
		.statusMode(statusMode), .busReadMode(busReadMode));

	fos_host_model fos_host_model_i (.core_clk(core_clk), .ceN(ceN), .oeN(oeN),
		.lowByteDataLines(lowByteDataLines), .lowByteOe(lowByteOe));

	////////////////////////////////////////////////////////////////////////////////
	// algorithm engine stand-in, latency drawn per operation
	always @(negedge core_clk) begin : engine
		fos_pkg::fos_eng_rsp_t rsp;
		rsp = '0;
		if (engReq.start)
			starts++;
		if (engReq.start || engReq.resume || engReq.suspend)
			reqErase = engReq.isErase;
		if (engReq.start || engReq.resume) begin
			engCnt = lat + int'(lfsr[2:0]);
		end else if (engReq.suspend && !finishOnSuspend) begin
			engCnt = 0;
			pauseCnt = 8;
		end else if (engCnt == 1) begin
			rsp.done = 1'b1;
			rsp.fail = engFail;
			engCnt = 0;
		end else if (engCnt > 1) begin
			engCnt--;
		end
		if (pauseCnt == 1)
			rsp.paused = 1'b1;
		if (pauseCnt > 0)
			pauseCnt--;
		engRsp = rsp;
	end

	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// expected word from the operation and the injected fault kind
	function automatic logic [7:0] expWord(input int c, input int k);
		logic er;
		er = (c == 2 || c == 4);
		case (k)
			1: return er ? 8'ha0 : 8'h90;
			2: return er ? 8'ha8 : 8'h98;
			3: return (c > 2) ? 8'h80 : (er ? 8'ha2 : 8'h92);
			4: return 8'hb0;
			default: return 8'h80;
		endcase
	endfunction

	task automatic doCmd(input int c, input logic pin, input logic lk, input logic se);
		@(negedge core_clk);
		cmdValid = 1'b1;
		cmd = fos_pkg::fos_cmd_t'(c[3:0]);
		programEraseEnablePin = pin;
		targetLocked = lk;
		cmdSeqError = se;
		@(negedge core_clk);
		cmdValid = 1'b0;
		cmd = fos_pkg::CMD_NONE;
		programEraseEnablePin = 1'b1;
		targetLocked = 1'b0;
		cmdSeqError = 1'b0;
		repeat (2) @(negedge core_clk);
	endtask

	task automatic report_and_stop();
		if (failures == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		#300000;
		failures++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(negedge core_clk);
		srst = 1'b0;
		`CHK("reset data", 8'h80, lowByteDataLines)
		`CHK("reset oe", 8'h00, lowByteOe)
		for (int c = 1; c <= 4; c++) begin
			for (int k = 0; k < 5; k++) begin
				lfsr = nextRand(lfsr);
				cfgReadMode = lfsr[4] ? fos_pkg::RD_BURST : fos_pkg::fos_rdmode_t'({1'b0, lfsr[3]});
				engFail = (k == 1);
				doCmd(c, k != 2, k == 3, k == 4);
				fos_host_model_i.pollIdle(rd, oe);
				`CHK("op status", expWord(c, k), rd)
				`CHK("idle oe", 8'hff, oe)
				`CHK("status mode", 1'b1, statusMode)
				`CHK("status rdmode", (cfgReadMode == fos_pkg::RD_BURST) ?
					fos_pkg::RD_SINGLE_SYNC : cfgReadMode, busReadMode)
				if (k == 0)
					`CHK("start kind", c == 2 || c == 4, reqErase)
				if (expWord(c, k) != 8'h80) begin
					n = starts;
					doCmd(c, 1'b1, 1'b0, 1'b0);
					fos_host_model_i.pollIdle(rd, oe);
					`CHK("sticky", expWord(c, k), rd)
					`CHK("no start", n, starts)
				end
				doCmd(fos_pkg::CMD_CLEAR, 1'b1, 1'b0, 1'b0);
				fos_host_model_i.readOnce(rd, oe);
				`CHK("cleared", 8'h80, rd)
			end
		end
		for (int m = 0; m < 3; m++) begin
			cfgReadMode = fos_pkg::fos_rdmode_t'(m[1:0]);
			doCmd(fos_pkg::CMD_RD_STATUS, 1'b1, 1'b0, 1'b0);
			`CHK("rdmode in status", (m == 2) ? 2'h1 : m[1:0], busReadMode)
			doCmd(fos_pkg::CMD_RD_ARRAY, 1'b1, 1'b0, 1'b0);
			`CHK("array mode", 1'b0, statusMode)
			`CHK("array rdmode", m[1:0], busReadMode)
		end
		// erase suspend, program inside it, then both resumes
		lat = 30;
		engFail = 1'b0;
		doCmd(fos_pkg::CMD_ERASE, 1'b1, 1'b0, 1'b0);
		fos_host_model_i.readOnce(rd, oe);
		`CHK("busy oe", 8'h80, oe)
		`CHK("busy idle", 1'b0, rd[7])
		doCmd(fos_pkg::CMD_SUSPEND, 1'b1, 1'b0, 1'b0);
		fos_host_model_i.readOnce(rd, oe);
		`CHK("suspending", 1'b0, rd[7])
		fos_host_model_i.pollIdle(rd, oe);
		`CHK("erase paused", 8'hc0, rd)
		`CHK("suspend kind", 1'b1, reqErase)
		doCmd(fos_pkg::CMD_PROGRAM, 1'b1, 1'b0, 1'b0);
		doCmd(fos_pkg::CMD_SUSPEND, 1'b1, 1'b0, 1'b0);
		fos_host_model_i.pollIdle(rd, oe);
		`CHK("both paused", 8'hc4, rd)
		`CHK("suspend kind", 1'b0, reqErase)
		doCmd(fos_pkg::CMD_RESUME, 1'b1, 1'b0, 1'b0);
		fos_host_model_i.readOnce(rd, oe);
		`CHK("program resumed", 1'b0, rd[7])
		`CHK("resume kind", 1'b0, reqErase)
		fos_host_model_i.pollIdle(rd, oe);
		`CHK("program done", 8'hc0, rd)
		doCmd(fos_pkg::CMD_RESUME, 1'b1, 1'b0, 1'b0);
		fos_host_model_i.pollIdle(rd, oe);
		`CHK("erase done", 8'h80, rd)
		`CHK("resume kind", 1'b1, reqErase)
		// engine finishes instead of pausing after a suspend
		lat = 10;
		finishOnSuspend = 1'b1;
		doCmd(fos_pkg::CMD_ERASE, 1'b1, 1'b0, 1'b0);
		doCmd(fos_pkg::CMD_SUSPEND, 1'b1, 1'b0, 1'b0);
		fos_host_model_i.pollIdle(rd, oe);
		`CHK("finished not paused", 8'h80, rd)
		finishOnSuspend = 1'b0;
		// reset in mid-run with errors left set
		lat = 3;
		doCmd(fos_pkg::CMD_PROGRAM, 1'b0, 1'b0, 1'b0);
		fos_host_model_i.pollIdle(rd, oe);
		`CHK("before reset", 8'h98, rd)
		srst = 1'b1;
		repeat (2) @(negedge core_clk);
		srst = 1'b0;
		doCmd(fos_pkg::CMD_RD_STATUS, 1'b1, 1'b0, 1'b0);
		fos_host_model_i.readOnce(rd, oe);
		`CHK("after reset", 8'h80, rd)
		report_and_stop();
	end
endmodule
